// ==== logic/pmbs_map.vh ====
/*
 Constants of the rectifier management slave: clock rate, timing figures,
 address fields, command codes and limits.
 Assumes inclusion by bare name from the logic/ folder.
*/
`ifndef PMBS_MAP_VH
`define PMBS_MAP_VH

`define PMBS_CLK_KHZ 40000
`define PMBS_STRETCH_MS 25
`define PMBS_IDLE_S 5

`define PMBS_ADDR_TGT 7:4
`define PMBS_ADDR_HW 3:1
`define PMBS_ADDR_RW 0
`define PMBS_TGT_CTRL 4'h8
`define PMBS_TGT_EEP 4'hA
`define PMBS_TGT_SEL 4'hE
`define PMBS_BCAST 8'h00

`define PMBS_CMD_OPER 8'h01
`define PMBS_CMD_CLEAR 8'h03
`define PMBS_CMD_VOUT 8'h21
`define PMBS_CMD_OVLIM 8'h40
`define PMBS_CMD_RDSTAT 8'hD0

`define PMBS_LEN_RD 3'h6
`define PMBS_LEN_BAD 3'h7

`define PMBS_VOUT_MIN 16'h41A0
`define PMBS_VOUT_MAX 16'h5AA0

`define PMBS_CRC_POLY 8'h07
`define PMBS_CRC_INIT 8'h00
`define PMBS_FILL 8'hFF

`endif

// ==== logic/pmbs_crc8.v ====
/*
 One byte step of the packet check: CRC-8, polynomial x^8+x^2+x+1, MSB first.
 Assumes the caller holds the running value and applies one byte per step.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmbs_map.vh"

module pmbs_crc8 (
   input wire [7:0] crc_in,
   input wire [7:0] data_in,
   output reg [7:0] crc_out
);
   reg [7:0] c;
   integer i;

   always @* begin
      c = crc_in ^ data_in;
      for (i = 0; i < 8; i = i + 1) begin
         if (c[7]) begin
            c = {c[6:0], 1'b0} ^ `PMBS_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      crc_out = c;
   end
endmodule // pmbs_crc8

`default_nettype wire

// ==== logic/pmbs_tmr.v ====
/*
 Quiet-time counter: counts cycles while running, flags reaching LIMIT.
 Assumes clear or a stop of run_in restarts it from zero.
*/
`timescale 1ns/1ps
`default_nettype none

module pmbs_tmr #(
   parameter [27:0] LIMIT = 28'h00003E8
) (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire clear_in,
   input wire run_in,
   output wire expired_out
);
   reg [27:0] cnt;

   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt <= 28'h0000000;
      end else if (clear_in || !run_in) begin
         cnt <= 28'h0000000;
      end else if (cnt != LIMIT) begin
         cnt <= cnt + 28'h0000001;
      end
   end

   assign expired_out = (cnt == LIMIT);
endmodule // pmbs_tmr

`default_nettype wire

// ==== logic/pmbs_slave.v ====
/*
 Two-wire management slave of the rectifier controller: address decode,
 write commands with packet check, reads with clock stretching, alert.
 Assumes scl/sda inputs synchronous to clk_sys_in and wired-AND pins outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmbs_map.vh"

module pmbs_slave #(
   parameter [27:0] STRETCH_CYCLES = `PMBS_STRETCH_MS * `PMBS_CLK_KHZ,
   parameter [27:0] IDLE_CYCLES = `PMBS_IDLE_S * 1000 * `PMBS_CLK_KHZ
) (
   input wire clk_sys_in,
   input wire rstn_in,
   input wire scl_in,
   output wire scl_out,
   output reg scl_oe_out,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe_out,
   output wire alert_out,
   output reg alert_oe_out,
   input wire shelf_addr_bit_in,
   input wire slot_addr_bit_hi_in,
   input wire slot_addr_bit_lo_in,
   input wire [8:0] fault_in,
   input wire out_on_in,
   output wire rd_req_out,
   output wire [7:0] rd_cmd_out,
   input wire rd_valid_in,
   input wire [7:0] rd_byte_in,
   input wire rd_last_in,
   output reg cmd_valid_out,
   output wire [7:0] cmd_code_out,
   output wire [23:0] cmd_data_out,
   output reg status_read_done_out,
   output reg pec_err_out,
   output reg invalid_cmd_out,
   output reg data_err_out,
   output reg [1:0] peer_hit_out,
   output reg reinit_out
);
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_RX = 6'h02;
   localparam [5:0] ST_ACK = 6'h04;
   localparam [5:0] ST_PREP = 6'h08;
   localparam [5:0] ST_TX = 6'h10;
   localparam [5:0] ST_MACK = 6'h20;

   reg [5:0] state;
   reg scl_q;
   reg sda_q;
   reg [7:0] shift;
   reg [2:0] bitn;
   reg byte_full;
   reg first;
   reg in_msg;
   reg rd_mode;
   reg got_cmd;
   reg [7:0] cmd;
   reg [7:0] buf0;
   reg [7:0] buf1;
   reg [7:0] buf2;
   reg [2:0] wr_cnt;
   reg [7:0] crc;
   reg pec_due;
   reg pec_sent;
   reg mack;
   reg [8:0] fault_q;
   reg out_q;
   reg clr_d;

   // Output lengths of write commands; read-only and unknown codes marked
   function [2:0] cmd_len;
      input [7:0] c;
      begin
         case (c)
            `PMBS_CMD_OPER: cmd_len = 3'h1;
            `PMBS_CMD_CLEAR: cmd_len = 3'h0;
            `PMBS_CMD_VOUT: cmd_len = 3'h2;
            `PMBS_CMD_OVLIM: cmd_len = 3'h2;
            8'hD2, 8'hD3, 8'hD6, 8'hD7: cmd_len = 3'h0;
            8'hD8, 8'hD9, 8'hDA, 8'hE0, 8'hE2: cmd_len = 3'h0;
            8'hDF: cmd_len = 3'h3;
            `PMBS_CMD_RDSTAT, 8'hDC, 8'hDD, 8'hDE, 8'hE1: cmd_len = `PMBS_LEN_RD;
            default: cmd_len = `PMBS_LEN_BAD;
         endcase
      end
   endfunction

   // Pins only ever pull low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign alert_out = 1'b0;

   // Bus events from one-cycle-old samples; fast enough for both rates
   wire scl_rise = scl_in & ~scl_q;
   wire scl_fall = ~scl_in & scl_q;
   wire start_ev = scl_in & scl_q & sda_q & ~sda_in;
   wire stop_ev = scl_in & scl_q & ~sda_q & sda_in;
   wire activity = (scl_in ^ scl_q) | (sda_in ^ sda_q);

   wire [2:0] my_addr = {shelf_addr_bit_in, slot_addr_bit_hi_in, slot_addr_bit_lo_in};
   wire hw_hit = (shift[`PMBS_ADDR_HW] == my_addr);
   wire ctrl_hit = (shift[`PMBS_ADDR_TGT] == `PMBS_TGT_CTRL) & hw_hit;
   wire bc_hit = (shift == `PMBS_BCAST);
   wire is_read = shift[`PMBS_ADDR_RW];
   wire rx_done = (state == ST_RX) & scl_fall & byte_full;

   wire [2:0] len = cmd_len(cmd);
   wire len_known = (len != `PMBS_LEN_RD) & (len != `PMBS_LEN_BAD);
   wire len_ok = len_known & (wr_cnt == len + 3'h1);
   wire [15:0] vout = {buf1, buf0};
   wire vout_bad = (cmd == `PMBS_CMD_VOUT) & ((vout < `PMBS_VOUT_MIN) | (vout > `PMBS_VOUT_MAX));

   wire wr_end = stop_ev & in_msg & ~rd_mode & got_cmd;
   wire rd_ok = ctrl_hit & in_msg & got_cmd & (len == `PMBS_LEN_RD);
   wire rd_bad = rx_done & first & is_read & ctrl_hit & in_msg & got_cmd & ~rd_ok;
   wire inv_set = (wr_end & (len == `PMBS_LEN_BAD)) | rd_bad;
   wire pec_set = wr_end & len_ok & (crc != `PMBS_CRC_INIT);
   wire data_set = wr_end & len_ok & (crc == `PMBS_CRC_INIT) & vout_bad;
   // Running check over data plus received check byte is zero when intact
   wire exec = wr_end & len_ok & (crc == `PMBS_CRC_INIT) & ~vout_bad;
   wire clear_ev = exec & (cmd == `PMBS_CMD_CLEAR);

   wire stretch_exp;
   wire idle_exp;
   wire to_ev = (state == ST_PREP) & stretch_exp;
   wire [7:0] tx_byte = pec_sent ? `PMBS_FILL :
                        pec_due ? crc :
                        stretch_exp ? `PMBS_FILL : rd_byte_in;
   wire tx_ready = pec_due | pec_sent | rd_valid_in | stretch_exp;
   wire [7:0] crc_byte = (state == ST_PREP) ? tx_byte : shift;
   wire [7:0] crc_next;

   assign rd_req_out = (state == ST_PREP) & ~pec_due & ~pec_sent;
   assign rd_cmd_out = cmd;
   assign cmd_code_out = cmd;
   assign cmd_data_out = {buf2, buf1, buf0};

   pmbs_crc8 u_crc (
      .crc_in(crc),
      .data_in(crc_byte),
      .crc_out(crc_next)
   );

   // Stretch limit: the clock is let go however late the read data is
   pmbs_tmr #(.LIMIT(STRETCH_CYCLES)) u_stretch (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .clear_in(1'b0),
      .run_in(state == ST_PREP),
      .expired_out(stretch_exp)
   );

   pmbs_tmr #(.LIMIT(IDLE_CYCLES)) u_idle (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .clear_in(activity | idle_exp),
      .run_in(1'b1),
      .expired_out(idle_exp)
   );

   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         shift <= 8'h00;
         bitn <= 3'h0;
         byte_full <= 1'b0;
         first <= 1'b0;
         in_msg <= 1'b0;
         rd_mode <= 1'b0;
         got_cmd <= 1'b0;
         cmd <= 8'h00;
         buf0 <= 8'h00;
         buf1 <= 8'h00;
         buf2 <= 8'h00;
         wr_cnt <= 3'h0;
         crc <= `PMBS_CRC_INIT;
         pec_due <= 1'b0;
         pec_sent <= 1'b0;
         mack <= 1'b0;
         sda_oe_out <= 1'b0;
         scl_oe_out <= 1'b0;
         peer_hit_out <= 2'h0;
         reinit_out <= 1'b0;
         status_read_done_out <= 1'b0;
         cmd_valid_out <= 1'b0;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         // Held one cycle past the load so data settles before release
         scl_oe_out <= (state == ST_PREP);
         reinit_out <= idle_exp;
         cmd_valid_out <= exec;
         status_read_done_out <= 1'b0;
         if (idle_exp) begin
            state <= ST_IDLE;
            in_msg <= 1'b0;
            sda_oe_out <= 1'b0;
            peer_hit_out <= 2'h0;
         end else if (start_ev) begin
            state <= ST_RX;
            bitn <= 3'h0;
            byte_full <= 1'b0;
            first <= 1'b1;
            rd_mode <= 1'b0;
            pec_due <= 1'b0;
            pec_sent <= 1'b0;
            sda_oe_out <= 1'b0;
            if (!in_msg) begin
               crc <= `PMBS_CRC_INIT;
               got_cmd <= 1'b0;
               wr_cnt <= 3'h0;
            end
         end else if (stop_ev) begin
            state <= ST_IDLE;
            in_msg <= 1'b0;
            sda_oe_out <= 1'b0;
            peer_hit_out <= 2'h0;
         end else begin
            case (state)
               ST_IDLE: begin
                  sda_oe_out <= 1'b0;
               end
               ST_RX: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_in};
                     bitn <= bitn + 3'h1;
                     byte_full <= (bitn == 3'h7);
                  end else if (rx_done) begin
                     byte_full <= 1'b0;
                     first <= 1'b0;
                     if (first) begin
                        peer_hit_out <= {(shift[`PMBS_ADDR_TGT] == `PMBS_TGT_SEL) & hw_hit,
                                         (shift[`PMBS_ADDR_TGT] == `PMBS_TGT_EEP) & hw_hit};
                        if (is_read ? rd_ok : (ctrl_hit | bc_hit)) begin
                           crc <= crc_next;
                           rd_mode <= is_read;
                           in_msg <= 1'b1;
                           sda_oe_out <= 1'b1;
                           state <= ST_ACK;
                        end else begin
                           state <= ST_IDLE;
                        end
                     end else begin
                        crc <= crc_next;
                        if (!got_cmd) begin
                           cmd <= shift;
                           got_cmd <= 1'b1;
                        end else begin
                           if (wr_cnt == 3'h0) begin
                              buf0 <= shift;
                           end
                           if (wr_cnt == 3'h1) begin
                              buf1 <= shift;
                           end
                           if (wr_cnt == 3'h2 && len == 3'h3) begin
                              buf2 <= shift;
                           end
                           if (wr_cnt != 3'h7) begin
                              wr_cnt <= wr_cnt + 3'h1;
                           end
                        end
                        sda_oe_out <= 1'b1;
                        state <= ST_ACK;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     sda_oe_out <= 1'b0;
                     bitn <= 3'h0;
                     // Stretch begins only once the ninth bit is over
                     state <= rd_mode ? ST_PREP : ST_RX;
                  end
               end
               ST_PREP: begin
                  if (tx_ready) begin
                     shift <= tx_byte;
                     sda_oe_out <= ~tx_byte[7];
                     bitn <= 3'h0;
                     state <= ST_TX;
                     if (pec_due) begin
                        pec_due <= 1'b0;
                        pec_sent <= 1'b1;
                     end else if (!pec_sent) begin
                        crc <= crc_next;
                        pec_due <= stretch_exp | (rd_valid_in & rd_last_in);
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bitn == 3'h7) begin
                        sda_oe_out <= 1'b0;
                        state <= ST_MACK;
                     end else begin
                        bitn <= bitn + 3'h1;
                        shift <= {shift[6:0], 1'b0};
                        sda_oe_out <= ~shift[6];
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     mack <= ~sda_in;
                  end else if (scl_fall) begin
                     if (mack) begin
                        state <= ST_PREP;
                     end else begin
                        state <= ST_IDLE;
                        status_read_done_out <= pec_sent & (cmd == `PMBS_CMD_RDSTAT);
                     end
                  end
               end
               default: begin
                  state <= ST_IDLE;
                  sda_oe_out <= 1'b0;
               end
            endcase
         end
      end
   end

   // Sticky status flags and alert; a set always beats a clear
   wire alarm_now = |fault_in;
   wire alert_set = (|(fault_in ^ fault_q)) | pec_set | inv_set | data_set | to_ev | (clr_d & alarm_now);
   wire recycle = out_on_in & ~out_q;
   wire alert_rel = clear_ev | status_read_done_out | recycle;

   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fault_q <= 9'h000;
         out_q <= 1'b0;
         clr_d <= 1'b0;
         alert_oe_out <= 1'b0;
         pec_err_out <= 1'b0;
         invalid_cmd_out <= 1'b0;
         data_err_out <= 1'b0;
      end else begin
         fault_q <= fault_in;
         out_q <= out_on_in;
         clr_d <= alert_rel;
         alert_oe_out <= alert_set | (alert_oe_out & ~alert_rel);
         pec_err_out <= pec_set | (pec_err_out & ~clear_ev);
         invalid_cmd_out <= inv_set | (invalid_cmd_out & ~clear_ev);
         data_err_out <= data_set | (data_err_out & ~clear_ev);
      end
   end
endmodule // pmbs_slave

`default_nettype wire

// ==== tb/pmbs_slave_sva.sv ====
/*
 Checker of the management slave ports: stretch, data timing, alert, pulses.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module pmbs_slave_sva #(
   parameter [27:0] STRETCH_CYCLES = 28'h00F4240,
   parameter [27:0] IDLE_CYCLES = 28'hBEBC200
) (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic scl_oe_out,
   input wire logic sda_oe_out,
   input wire logic alert_oe_out,
   input wire logic [8:0] fault_in,
   input wire logic out_on_in,
   input wire logic [7:0] rd_cmd_out,
   input wire logic cmd_valid_out,
   input wire logic status_read_done_out,
   input wire logic pec_err_out,
   input wire logic invalid_cmd_out,
   input wire logic data_err_out,
   input wire logic [1:0] peer_hit_out,
   input wire logic reinit_out
);
   logic [27:0] st_cnt;
   logic [27:0] q_cnt;
   logic scl_d;
   logic sda_d;
   always @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_cnt <= 28'h0000000;
         q_cnt <= 28'h0000000;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         st_cnt <= scl_oe_out ? st_cnt + 28'h0000001 : 28'h0000000;
         q_cnt <= (scl_in != scl_d || sda_in != sda_d || reinit_out) ? 28'h0000000 : q_cnt + 28'h0000001;
         scl_d <= scl_in;
         sda_d <= sda_in;
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   sequence s_bus_idle;
      scl_in && sda_in && $past(scl_in, 2);
   endsequence
   sequence s_flag_rise;
      $rose(pec_err_out) || $rose(invalid_cmd_out) || $rose(data_err_out);
   endsequence
   a_stretch_len: assert property (st_cnt <= STRETCH_CYCLES + 28'h0000002)
      else $error("clock held low too long");
   a_stretch_start: assert property ($rose(scl_oe_out) |-> !scl_in && !$past(scl_in))
      else $error("stretch began with clock high");
   a_data_clk_low: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in))
      else $error("data moved while clock high");
   a_exec_at_stop: assert property (cmd_valid_out |-> s_bus_idle)
      else $error("command executed outside stop");
   a_exec_pulse: assert property (cmd_valid_out |=> !cmd_valid_out)
      else $error("command pulse too long");
   a_fault_alert: assert property ($changed(fault_in) |-> ##[1:2] alert_oe_out)
      else $error("alarm change without alert");
   a_flag_alert: assert property (s_flag_rise |-> ##[0:2] alert_oe_out)
      else $error("error flag without alert");
   a_alert_release: assert property ($fell(alert_oe_out) |-> cmd_valid_out || status_read_done_out
      || $past(status_read_done_out) || (out_on_in && !$past(out_on_in, 3)))
      else $error("alert released without cause");
   a_done_status: assert property (status_read_done_out |-> rd_cmd_out == 8'hD0)
      else $error("status done for other command");
   a_target_one: assert property ($onehot0(peer_hit_out))
      else $error("two targets matched");
   a_reinit_quiet: assert property (reinit_out |-> q_cnt + 28'h0000004 >= IDLE_CYCLES
      && q_cnt <= IDLE_CYCLES + 28'h0000004)
      else $error("reinit at wrong quiet time");
endmodule // pmbs_slave_sva
bind pmbs_slave pmbs_slave_sva #(.STRETCH_CYCLES(STRETCH_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)) u_sva (
   .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in),
   .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out), .alert_oe_out(alert_oe_out),
   .fault_in(fault_in), .out_on_in(out_on_in), .rd_cmd_out(rd_cmd_out), .cmd_valid_out(cmd_valid_out),
   .status_read_done_out(status_read_done_out), .pec_err_out(pec_err_out),
   .invalid_cmd_out(invalid_cmd_out), .data_err_out(data_err_out), .peer_hit_out(peer_hit_out),
   .reinit_out(reinit_out));
`default_nettype wire

// ==== tb/pmbs_host.sv ====
/*
 Bus master model: pulls clock and data low, otherwise releases them.
 Assumes the bench wires its pulls with the slave's onto pulled-up lines.
*/
`timescale 1ns/1ps
`default_nettype none
module pmbs_host (
   input wire logic clk_sys_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output var logic scl_low_out,
   output var logic sda_low_out
);
   int q = 25;
   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   task automatic set(input logic c, input logic d);
      scl_low_out = c;
      sda_low_out = d;
      w(q);
   endtask
   // Release the clock, then wait out any stretch before sampling
   task automatic bitx(input logic b, output logic r);
      int i;
      set(1'b1, !b);
      scl_low_out = 1'b0;
      i = 0;
      while (scl_in !== 1'b1 && i < 4000) begin
         w(1);
         i++;
      end
      if (i == 4000) begin
         tb_pmbs_slave.mismatches++;
         $display("[ERR] clock release expected 1 seen 0");
         tb_pmbs_slave.end_of_test();
      end
      w(q);
      r = sda_in;
      w(q);
      set(1'b1, sda_low_out);
   endtask
   task automatic start();
      set(1'b1, 1'b0);
      set(1'b0, 1'b0);
      set(1'b0, 1'b1);
      set(1'b1, 1'b1);
   endtask
   task automatic stop();
      set(1'b1, 1'b1);
      set(1'b0, 1'b1);
      set(1'b0, 1'b0);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ak = !r;
   endtask
   task automatic rbyte(input logic ak, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(!ak, r);
   endtask
endmodule // pmbs_host
`default_nettype wire

// ==== tb/tb_pmbs_slave.sv ====
/*
 Bench of the management slave: host model on the wires, read data feed.
 Assumes pmbs_host beside the slave and the checker bound to it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_pmbs_slave;
   logic clk_sys_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [8:0] fault_in = 9'h000;
   logic out_on_in = 1'b1;
   logic rd_valid_in = 1'b0;
   logic [7:0] rd_byte_in = 8'h00;
   logic rd_last_in = 1'b0;
   logic [2:0] uaddr = 3'h5;
   wire scl_oe_out, sda_oe_out, alert_oe_out, rd_req_out, cmd_valid_out, status_read_done_out;
   wire pec_err_out, invalid_cmd_out, data_err_out, reinit_out, h_scl, h_sda;
   wire [7:0] rd_cmd_out, cmd_code_out;
   wire [23:0] cmd_data_out;
   wire [1:0] peer_hit_out;
   wire scl_w = !(h_scl || scl_oe_out);
   wire sda_w = !(h_sda || sda_oe_out);
   wire alert_w = !alert_oe_out;
   int mismatches = 0;
   int n_tests = 0;
   int n_cv = 0, n_srd = 0, n_ri = 0, fi = 0;
   logic [7:0] cv_code;
   logic [7:0] fb [2];
   logic [23:0] cv_data;
   logic feed = 1'b0;
   logic saw_st = 1'b0;
   always #12.5 clk_sys_in = !clk_sys_in;
   pmbs_slave #(.STRETCH_CYCLES(28'h000012C), .IDLE_CYCLES(28'h0000BB8)) uut (
      .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe_out),
      .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe_out), .alert_out(), .alert_oe_out(alert_oe_out),
      .shelf_addr_bit_in(uaddr[2]), .slot_addr_bit_hi_in(uaddr[1]), .slot_addr_bit_lo_in(uaddr[0]),
      .fault_in(fault_in), .out_on_in(out_on_in), .rd_req_out(rd_req_out), .rd_cmd_out(rd_cmd_out),
      .rd_valid_in(rd_valid_in), .rd_byte_in(rd_byte_in), .rd_last_in(rd_last_in),
      .cmd_valid_out(cmd_valid_out), .cmd_code_out(cmd_code_out), .cmd_data_out(cmd_data_out),
      .status_read_done_out(status_read_done_out), .pec_err_out(pec_err_out),
      .invalid_cmd_out(invalid_cmd_out), .data_err_out(data_err_out), .peer_hit_out(peer_hit_out),
      .reinit_out(reinit_out));
   pmbs_host host (.clk_sys_in(clk_sys_in), .scl_in(scl_w), .sda_in(sda_w), .scl_low_out(h_scl),
      .sda_low_out(h_sda));
   always @(posedge clk_sys_in) begin
      if (cmd_valid_out === 1'b1) begin
         n_cv++;
         cv_code = cmd_code_out;
         cv_data = cmd_data_out;
      end
      if (status_read_done_out === 1'b1) n_srd++;
      if (reinit_out === 1'b1) n_ri++;
      if (scl_oe_out === 1'b1) saw_st = 1'b1;
      if (rd_valid_in && rd_req_out === 1'b1) fi++;
   end
   always @(negedge clk_sys_in) begin
      rd_valid_in <= feed && rd_req_out === 1'b1;
      rd_byte_in <= fb[fi[0]];
      rd_last_in <= fi[0];
   end
   function automatic [7:0] crc8(input [7:0] c, input [7:0] d);
      c = c ^ d;
      for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      return c;
   endfunction
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Write message; pm 0 leaves out the check byte, 2 corrupts it
   task automatic wmsg(input [7:0] a, input [7:0] c, input int n, input [23:0] d, input int pm, output logic ak);
      logic [7:0] k;
      logic x;
      host.start();
      host.wbyte(a, ak);
      host.wbyte(c, x);
      k = crc8(crc8(8'h00, a), c);
      for (int i = 0; i < n; i++) begin
         host.wbyte(d[8*i+:8], x);
         k = crc8(k, d[8*i+:8]);
      end
      if (pm > 0) host.wbyte(k ^ {7'h00, pm == 2}, x);
      host.stop();
      host.w(4);
   endtask
   task automatic rd_open(output logic ak);
      host.start();
      host.wbyte(8'h8A, ak);
      host.wbyte(8'hD0, ak);
      host.start();
      host.wbyte(8'h8B, ak);
   endtask
   task automatic t_pec();
      logic ak;
      int n = n_cv;
      chk("alert idle", 1'h1, alert_w);
      wmsg(8'h8A, 8'h21, 2, 24'h004ED4, 0, ak);
      wmsg(8'h8A, 8'h21, 2, 24'h004ED4, 2, ak);
      chk("cmd count", n, n_cv);
      chk("pec flag", 1'h1, pec_err_out);
      chk("alert line", 1'h0, alert_w);
      $display("test pec done");
   endtask
   task automatic t_range();
      logic ak;
      int n = n_cv;
      wmsg(8'h8A, 8'h21, 2, 24'h0041A0, 1, ak);
      chk("vout low", 24'h0041A0, cv_data);
      wmsg(8'h8A, 8'h21, 2, 24'h005AA0, 1, ak);
      chk("vout high", 24'h005AA0, cv_data);
      chk("cmd count", n + 2, n_cv);
      wmsg(8'h8A, 8'h21, 2, 24'h00419F, 1, ak);
      chk("range flag", 1'h1, data_err_out);
      $display("test range done");
   endtask
   task automatic t_codes();
      logic [7:0] c [13] = '{8'h01, 8'h40, 8'hD2, 8'hD3, 8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDF, 8'hE0,
         8'hE2, 8'h03};
      int l [13] = '{1, 2, 0, 0, 0, 0, 0, 0, 0, 3, 0, 0, 0};
      logic ak;
      int n;
      for (int i = 0; i < 13; i++) begin
         n = n_cv;
         wmsg(8'h8A, c[i], l[i], 24'h324E80, 1, ak);
         chk("cmd count", n + 1, n_cv);
         chk("cmd code", c[i], cv_code);
      end
      chk("pec cleared", 1'h0, pec_err_out);
      chk("alert line", 1'h1, alert_w);
      wmsg(8'h8A, 8'h55, 0, 24'h000000, 1, ak);
      chk("invalid flag", 1'h1, invalid_cmd_out);
      chk("alert line", 1'h0, alert_w);
      $display("test codes done");
   endtask
   task automatic t_addr();
      logic ak;
      int n = n_cv;
      host.start();
      host.wbyte(8'hAA, ak);
      chk("eeprom hit", 2'h1, peer_hit_out);
      host.stop();
      host.start();
      host.wbyte(8'hEA, ak);
      chk("selector hit", 2'h2, peer_hit_out);
      host.wbyte(8'h00, ak);
      host.wbyte(8'h0E, ak);
      host.stop();
      wmsg(8'h8C, 8'h03, 0, 24'h000000, 1, ak);
      chk("other unit ack", 1'h0, ak);
      uaddr = 3'h6;
      wmsg(8'h8C, 8'hD2, 0, 24'h000000, 1, ak);
      chk("unit 6 ack", 1'h1, ak);
      uaddr = 3'h5;
      wmsg(8'h00, 8'hD2, 0, 24'h000000, 1, ak);
      chk("broadcast ack", 1'h1, ak);
      chk("cmd count", n + 2, n_cv);
      wmsg(8'h01, 8'hD2, 0, 24'h000000, 1, ak);
      chk("broadcast read ack", 1'h0, ak);
      $display("test address done");
   endtask
   task automatic t_read();
      logic ak;
      logic [7:0] b1, b2, p;
      int n = n_srd;
      fault_in = 9'h004;
      fi = 0;
      fb = '{8'h12, 8'h34};
      feed = 1'b1;
      saw_st = 1'b0;
      rd_open(ak);
      chk("read ack", 1'h1, ak);
      fault_in = 9'h000;
      host.rbyte(1'b1, b1);
      host.rbyte(1'b1, b2);
      host.rbyte(1'b0, p);
      host.stop();
      host.w(4);
      feed = 1'b0;
      chk("byte 1", 8'h12, b1);
      chk("byte 2", 8'h34, b2);
      chk("read pec", crc8(crc8(crc8(crc8(crc8(8'h00, 8'h8A), 8'hD0), 8'h8B), 8'h12), 8'h34), p);
      chk("stretched", 1'h1, saw_st);
      chk("done count", n + 1, n_srd);
      chk("alert line", 1'h1, alert_w);
      rd_open(ak);
      host.rbyte(1'b0, b1);
      host.stop();
      host.w(4);
      chk("timeout fill", 8'hFF, b1);
      chk("alert line", 1'h0, alert_w);
      $display("test read done");
   endtask
   task automatic t_fault();
      logic ak;
      host.w(4);
      out_on_in = 1'b0;
      host.w(4);
      out_on_in = 1'b1;
      host.w(4);
      chk("recycle release", 1'h1, alert_w);
      fault_in = 9'h100;
      host.w(4);
      wmsg(8'h8A, 8'h03, 0, 24'h000000, 1, ak);
      chk("relatch", 1'h0, alert_w);
      fault_in = 9'h000;
      wmsg(8'h8A, 8'h03, 0, 24'h000000, 1, ak);
      chk("clear release", 1'h1, alert_w);
      $display("test fault done");
   endtask
   task automatic t_slow();
      logic ak;
      int n = n_cv;
      host.q = 100;
      wmsg(8'h8A, 8'hD2, 0, 24'h000000, 1, ak);
      chk("slow cmd count", n + 1, n_cv);
      host.q = 25;
      n = n_ri;
      host.w(3100);
      chk("reinit count", n + 1, n_ri);
      $display("test slow and idle done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk_sys_in);
      rstn_in = 1'b1;
      host.w(4);
      t_pec();
      t_range();
      t_codes();
      t_addr();
      t_read();
      t_fault();
      t_slow();
      end_of_test();
   end
endmodule // tb_pmbs_slave
`default_nettype wire
